// [design/frc_pkg.sv]
package frc_pkg;
   // Command codes of the four configuration registers
   localparam logic [7:0] ADDR_SELECT_CMD = 8'h00_D3;
   localparam logic [7:0] OV_THRESH_CMD = 8'h00_D4;
   localparam logic [7:0] OV_RESP_CMD = 8'h00_D5;
   localparam logic [7:0] OT_OC_RESP_CMD = 8'h00_D6;
   // Values after reset
   localparam logic [7:0] ADDR_SELECT_RESET = 8'h00_00;
   localparam logic [7:0] OV_THRESH_RESET = 8'h00_00;
   localparam logic [7:0] OV_RESP_RESET = 8'h00_00;
   localparam logic [7:0] OT_OC_RESP_RESET = 8'h00_00;
   // Field positions
   localparam int ADDR_ENABLE_BIT = 7;
   localparam int NEG_DELAY_BIT = 3;
   localparam int NEG_LIMIT_BIT = 2;
   localparam int OC_ACTION_BIT = 3;
   localparam int OT_ACTION_BIT = 0;
   localparam logic [7:0] PROT_WRITE_MASK = 8'h00_0F;
   // Fixed off time between discharge pulses
   localparam int DISCHARGE_OFF_NS = 1000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int DISCHARGE_OFF_CYCLES = (DISCHARGE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Overvoltage response modes
   typedef enum logic [1:0] {
      FRC_LATCH_DISCHARGE = 2'b00,
      FRC_LATCH_NO_DISCHARGE = 2'b01,
      FRC_HICCUP_DISCHARGE = 2'b10,
      FRC_HICCUP_NO_DISCHARGE = 2'b11
   } frc_ov_mode_type;

   // Register write port
   typedef struct packed {
      logic write;
      logic [7:0] command;
      logic [7:0] data;
   } frc_write_type;

   // Decoded protection settings for the analog core
   typedef struct packed {
      logic [1:0] ovReleaseLevel;
      logic [1:0] ovTripLevel;
      logic negLimitDelay;
      logic negativeCurrentLimit;
      logic [1:0] ovActionSelect;
      logic overcurrentAction;
      logic [1:0] overtempHysteresis;
      logic overtempAction;
   } frc_settings_type;
endpackage

// [design/frc_fault_response_config.sv]
// Summary of operation
// - Bit7 set selects register address, else strap
// - Address select resets to zero
// - Bits 3:2 pick overvoltage release level
// - Bits 1:0 pick overvoltage trip level
// - Threshold register resets to zero
// - Bit3 picks delay, bit2 picks negative limit
// - Bits 1:0 pick latch/hiccup, discharge or not
// - Overvoltage sets three status flags, alert
// - Discharge: pulse low side until below release
// - Latch discharge re-arms, waits for power cycle
// - Latch no-discharge goes high-Z at zero current
// - Hiccup discharge restarts soft-start after release
// - Hiccup no-discharge restarts after negative limit
// - Response register resets to zero
// - Bit3 picks overcurrent latch or retry
// - Bits 2:1 pick overtemperature hysteresis
// - Bit0 picks overtemperature latch or retry
// - Thermal/overcurrent register resets to zero
// - Writes take effect at once
module frc_fault_response_config
   import frc_pkg::*;
#(
   // Clocks of fixed off time between discharge pulses
   // Kept a parameter so a bench can shorten the loop
   parameter int OFF_CYCLES = DISCHARGE_OFF_CYCLES
) (
   // Core clock and asynchronous reset
   input wire logic clk,
   input wire logic rst,
   // One-cycle write strobe with command and data
   input wire frc_write_type regWrite,
   // Read select; the answer comes back in the same cycle
   input wire logic [7:0] readCommand,
   output logic [7:0] readData,
   output logic readHit,
   // Address strap level and the address in use
   input wire logic [6:0] strapAddress,
   output logic [6:0] busAddress,
   // Decoded fields for the analog core
   output frc_settings_type settings,
   // Comparator and event inputs from the power stage
   input wire logic aboveTrip,
   input wire logic belowRelease,
   input wire logic negLimitReached,
   input wire logic currentZero,
   // Power or enable cycle seen by the core
   input wire logic restartCycle,
   // Host clear of the overvoltage status bits
   input wire logic statusClear,
   // Power stage controls
   output logic lowSideOn,
   output logic outputHighZ,
   output logic softStartRequest,
   output logic latchedOff,
   // Status bits and alert line
   output logic statusByteOv,
   output logic statusWordVout,
   output logic statusVoutOv,
   output logic alertActive
);
   // Stored registers
   // Address select keeps all eight bits
   logic [7:0] addrSelect;
   // Threshold fields, upper nibble always zero
   logic [7:0] ovThresh;
   // Negative limit, delay and response mode
   logic [7:0] ovResp;
   // Overcurrent and overtemperature responses
   logic [7:0] otOcResp;

   // Write strobes
   // Only an exact command match writes
   // Unknown commands fall through silently
   wire wrAddr = regWrite.write && regWrite.command == ADDR_SELECT_CMD;
   wire wrThresh = regWrite.write && regWrite.command == OV_THRESH_CMD;
   wire wrResp = regWrite.write && regWrite.command == OV_RESP_CMD;
   wire wrOtOc = regWrite.write && regWrite.command == OT_OC_RESP_CMD;
   // Reserved upper nibble is dropped on write
   // Masking here keeps reads and settings consistent
   // Address select is exempt, all its bits are used
   wire [7:0] maskedData = regWrite.data & PROT_WRITE_MASK;

   // Register file; reset values are zero
   // Writes land at the edge that takes the strobe
   // Limitation: no write protection of any kind
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // All four registers clear together
         addrSelect <= ADDR_SELECT_RESET;
         ovThresh <= OV_THRESH_RESET;
         ovResp <= OV_RESP_RESET;
         otOcResp <= OT_OC_RESP_RESET;
      end else begin
         // Address select, stored whole
         if (wrAddr) begin
            addrSelect <= regWrite.data;
         end
         // Overvoltage thresholds
         if (wrThresh) begin
            ovThresh <= maskedData;
         end
         // Overvoltage response
         if (wrResp) begin
            ovResp <= maskedData;
         end
         // Thermal and overcurrent response
         if (wrOtOc) begin
            otOcResp <= maskedData;
         end
      end
   end

   // Read mux; unknown commands read zero with no hit
   // No wait state: the bus slave may sample at once
   // Hits are exclusive, so the priority chain is harmless
   // Address select has no reserved bits to hide
   // Reserved nibbles read zero because they never store
   // Unmapped reads give zero rather than stale data
   wire hitAddr = readCommand == ADDR_SELECT_CMD;
   wire hitThresh = readCommand == OV_THRESH_CMD;
   wire hitResp = readCommand == OV_RESP_CMD;
   wire hitOtOc = readCommand == OT_OC_RESP_CMD;
   assign readHit = hitAddr | hitThresh | hitResp | hitOtOc;
   assign readData = hitAddr ? addrSelect :
                     hitThresh ? ovThresh :
                     hitResp ? ovResp :
                     hitOtOc ? otOcResp : 8'h00_00;

   // Live address choice
   // Takes effect on the next bus transfer
   // Strap is assumed stable while it is in use
   // Host must re-address after setting bit 7
   assign busAddress = addrSelect[ADDR_ENABLE_BIT] ? addrSelect[6:0] : strapAddress;

   // Settings go straight from the registers, no shadow copy
   // A shadow copy would delay changes until restart
   // Threshold fields feed the comparator references
   // Response fields feed the power stage sequencer
   // Thermal fields feed the temperature monitor
   // Core sees a new value one clock after the write
   // Limitation: the core must tolerate live changes
   assign settings.ovReleaseLevel = ovThresh[3:2];
   assign settings.ovTripLevel = ovThresh[1:0];
   assign settings.negLimitDelay = ovResp[NEG_DELAY_BIT];
   assign settings.negativeCurrentLimit = ovResp[NEG_LIMIT_BIT];
   assign settings.ovActionSelect = ovResp[1:0];
   assign settings.overcurrentAction = otOcResp[OC_ACTION_BIT];
   assign settings.overtempHysteresis = otOcResp[2:1];
   assign settings.overtempAction = otOcResp[OT_ACTION_BIT];

   // Mode sampled live each cycle
   // A change mid-response steers the next decision
   // Both fields are pure decodes of the stored bits
   // Every two-bit code is a legal mode
   frc_ov_mode_type mode;
   assign mode = frc_ov_mode_type'(ovResp[1:0]);
   wire withDischarge = mode == FRC_LATCH_DISCHARGE || mode == FRC_HICCUP_DISCHARGE;
   wire isLatch = mode == FRC_LATCH_DISCHARGE || mode == FRC_LATCH_NO_DISCHARGE;

   // Overvoltage sequencer states
   // Two codes are unused and fall back to regulation
   // States follow the four response modes
   typedef enum logic [2:0] {
      // Normal regulation
      FRC_RUN,
      // Low side on, discharging
      FRC_PULL_LOW,
      // Fixed off time between pulses
      FRC_OFF_WAIT,
      // Off until a power cycle
      FRC_LATCHED,
      // Output disabled, high impedance
      FRC_HIGH_Z,
      // One-cycle soft-start request
      FRC_RESTART
   } frc_ov_state_type;

   // Current and next sequencer state
   frc_ov_state_type state;
   frc_ov_state_type next_state;
   // Off-time counter, wide enough for long off times
   // Counts down to zero, then pulses again
   logic [15:0] offCount;
   logic [15:0] next_offCount;

   // Next-state logic for the overvoltage response
   // Defaults hold state, so no latch is inferred
   // Release wins over the negative limit in one cycle,
   // which avoids one needless extra discharge pulse
   always_comb begin
      next_state = state;
      next_offCount = offCount;
      unique case (state)
         // Regulating; a trip starts the response
         FRC_RUN: begin
            if (aboveTrip) begin
               next_state = FRC_PULL_LOW;
            end
         end
         FRC_PULL_LOW: begin
            // Discharge modes stop once feedback is below release
            if (withDischarge && belowRelease) begin
               next_state = isLatch ? FRC_LATCHED : FRC_RESTART;
            // Latch without discharge stops at zero current
            end else if (!withDischarge && isLatch && currentZero) begin
               next_state = FRC_HIGH_Z;
            // Hiccup without discharge restarts at the limit
            end else if (!withDischarge && !isLatch && negLimitReached) begin
               next_state = FRC_RESTART;
            // Discharge modes rest for the fixed off time
            end else if (withDischarge && negLimitReached) begin
               next_state = FRC_OFF_WAIT;
               next_offCount = 16'(OFF_CYCLES - 1);
            end
         end
         // Low side off; count down before the next pulse
         FRC_OFF_WAIT: begin
            // Feedback may settle below release while off
            if (belowRelease) begin
               next_state = isLatch ? FRC_LATCHED : FRC_RESTART;
            end else if (offCount == 16'h00_00) begin
               next_state = FRC_PULL_LOW;
            end else begin
               next_offCount = offCount - 16'h00_01;
            end
         end
         FRC_LATCHED: begin
            // Re-discharge on new trip; only a power cycle releases
            // Power cycle takes priority over a new trip
            if (restartCycle) begin
               next_state = FRC_RUN;
            end else if (aboveTrip) begin
               next_state = FRC_PULL_LOW;
            end
         end
         // Output stays disabled until a power cycle
         FRC_HIGH_Z: begin
            if (restartCycle) begin
               next_state = FRC_RUN;
            end
         end
         // Soft-start request lasts one cycle
         FRC_RESTART: begin
            next_state = FRC_RUN;
         end
         // Unused codes recover to regulation
         default: begin
            next_state = FRC_RUN;
         end
      endcase
   end

   // State registers
   // Reset leaves the converter regulating
   // Counter value is only read in the off state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= FRC_RUN;
         offCount <= 16'h00_00;
      end else begin
         state <= next_state;
         offCount <= next_offCount;
      end
   end

   // Core controls derived from state
   // Decoded from the state register, so free of glitches
   // Low side switch drive
   assign lowSideOn = state == FRC_PULL_LOW;
   // Output disabled
   assign outputHighZ = state == FRC_HIGH_Z;
   // Soft-start request
   assign softStartRequest = state == FRC_RESTART;
   // Either latched state blocks regulation
   assign latchedOff = state == FRC_LATCHED || state == FRC_HIGH_Z;

   // Sticky status flags; a new trip wins over a clear
   // Losing a trip to a clear would hide a real fault
   // Only a trip from regulation counts as a new event
   wire ovEvent = state == FRC_RUN && aboveTrip;
   always_ff @(posedge clk or posedge rst) begin
      // Reset clears every flag and the alert
      if (rst) begin
         statusByteOv <= 1'b0;
         statusWordVout <= 1'b0;
         statusVoutOv <= 1'b0;
         alertActive <= 1'b0;
      end else if (ovEvent) begin
         statusByteOv <= 1'b1;
         statusWordVout <= 1'b1;
         statusVoutOv <= 1'b1;
         alertActive <= 1'b1;
      // Host clear, only when no trip is pending
      end else if (statusClear) begin
         statusByteOv <= 1'b0;
         statusWordVout <= 1'b0;
         statusVoutOv <= 1'b0;
         alertActive <= 1'b0;
      end
   end
endmodule

// [verif/frc_assertions.sv]
module frc_assertions
   import frc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire frc_write_type regWrite,
   input wire logic [7:0] readCommand,
   input wire logic [7:0] readData,
   input wire logic readHit,
   input wire logic [6:0] strapAddress,
   input wire logic [6:0] busAddress,
   input wire frc_settings_type settings,
   input wire logic lowSideOn,
   input wire logic statusByteOv,
   input wire logic statusWordVout,
   input wire logic statusVoutOv,
   input wire logic alertActive
);
   timeunit 1ns;
   timeprecision 1ps;
   // Write strobes decoded per register
   wire logic [7:0] wd = regWrite.data;
   wire logic wA = regWrite.write && regWrite.command == ADDR_SELECT_CMD;
   wire logic wT = regWrite.write && regWrite.command == OV_THRESH_CMD;
   wire logic wR = regWrite.write && regWrite.command == OV_RESP_CMD;
   wire logic wO = regWrite.write && regWrite.command == OT_OC_RESP_CMD;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_addr_reg: assert property (wA && wd[7] |=> busAddress == $past(wd[6:0]))
      else $error("address not from register");
   a_addr_strap: assert property (wA && !wd[7] |=> busAddress == strapAddress)
      else $error("address not from strap");
   a_reset_vals: assert property ($fell(rst) |-> settings == '0)
      else $error("settings not zero after reset");
   a_thresh_live: assert property (wT |=> settings[11:8] == $past(wd[3:0]))
      else $error("threshold fields wrong");
   a_ov_resp: assert property (wR |=> settings[7:4] == $past(wd[3:0]))
      else $error("overvoltage response fields wrong");
   a_ot_oc: assert property (wO |=> settings[3:0] == $past(wd[3:0]))
      else $error("thermal fields wrong");
   a_reserved_zero: assert property (readHit && readCommand != ADDR_SELECT_CMD
      |-> readData[7:4] == 4'h0)
      else $error("reserved bits not zero");
   a_unmapped_zero: assert property (!readHit |-> readData == 8'h00)
      else $error("unmapped read not zero");
   a_ov_flags: assert property ($rose(alertActive) |-> statusByteOv && statusWordVout
      && statusVoutOv && lowSideOn)
      else $error("overvoltage flags incomplete");
endmodule
bind frc_fault_response_config frc_assertions frc_assertions_inst (.clk, .rst, .regWrite,
   .readCommand, .readData, .readHit, .strapAddress, .busAddress, .settings, .lowSideOn,
   .statusByteOv, .statusWordVout, .statusVoutOv, .alertActive);

// [verif/frc_host_model.sv]
module frc_host_model
   import frc_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] readData,
   output frc_write_type regWrite,
   output logic [7:0] readCommand
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regWrite = '0;
   initial readCommand = 8'h00;
   // Single-byte write; one idle edge between writes
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(posedge clk) regWrite <= '{1'b1, c, d};
      @(posedge clk) regWrite.write <= 1'b0;
      #1;
   endtask
   // Single-byte read; data is combinational
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      @(posedge clk) readCommand <= c;
      #1 d = readData;
   endtask
endmodule

// [verif/testbench.sv]
module testbench
   import frc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   // Trip, release, neg limit, zero current, restart, clear
   logic [5:0] evIn = '0;
   logic [6:0] strapAddress = 7'h2A;
   frc_write_type regWrite;
   frc_settings_type settings;
   logic [7:0] readCommand, readData, v;
   logic [6:0] busAddress;
   logic readHit, lowSideOn, outputHighZ, softStartRequest, latchedOff;
   logic statusByteOv, statusWordVout, statusVoutOv, alertActive;
   int badCount = 0;
   int totalChecks = 0;
   // Release event and end state per overvoltage mode
   int relEv[4] = '{1, 3, 1, 2};
   logic [2:0] expEnd[4] = '{3'b100, 3'b110, 3'b001, 3'b001};
   always #20 clk = ~clk;
   // Short off time keeps the discharge loop quick
   frc_fault_response_config #(.OFF_CYCLES(2)) frc_fault_response_config_inst (.clk, .rst,
      .regWrite, .readCommand, .readData, .readHit, .strapAddress, .busAddress, .settings,
      .aboveTrip(evIn[0]), .belowRelease(evIn[1]), .negLimitReached(evIn[2]),
      .currentZero(evIn[3]), .restartCycle(evIn[4]), .statusClear(evIn[5]), .lowSideOn,
      .outputHighZ, .softStartRequest, .latchedOff, .statusByteOv, .statusWordVout,
      .statusVoutOv, .alertActive);
   frc_host_model frc_host_model_inst (.clk, .readData, .regWrite, .readCommand);
   task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
      totalChecks++;
      if (s !== e) begin
         badCount++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // One-cycle event pulse, outputs settled after
   task automatic pulse(input int b);
      @(posedge clk) evIn[b] <= 1'b1;
      @(posedge clk) evIn[b] <= 1'b0;
      #1;
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         frc_host_model_inst.rd(ADDR_SELECT_CMD + 8'(r), v);
         chk("reset value", 12'(v), 12'h000);
      end
      chk("strap address", 12'(busAddress), 12'h02A);
      $display("reset test done");
      // Every code of every protection register field, reserved bits set
      for (int j = 0; j < 16; j++) begin
         for (int r = 1; r < 4; r++) begin
            frc_host_model_inst.wr(ADDR_SELECT_CMD + 8'(r), {4'hF, 4'(j)});
            frc_host_model_inst.rd(ADDR_SELECT_CMD + 8'(r), v);
            chk("readback", 12'(v), 12'(j));
         end
         chk("settings", settings, {3{4'(j)}});
      end
      frc_host_model_inst.wr(ADDR_SELECT_CMD, 8'h85);
      chk("register address", 12'(busAddress), 12'h005);
      frc_host_model_inst.wr(ADDR_SELECT_CMD, 8'h05);
      frc_host_model_inst.rd(ADDR_SELECT_CMD, v);
      chk("strap select", {busAddress, 5'(v)}, {7'h2A, 5'h05});
      frc_host_model_inst.rd(8'hD7, v);
      chk("unmapped", 12'({readHit, v}), 12'h000);
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         frc_host_model_inst.wr(OV_RESP_CMD, 8'(m));
         pulse(5);
         chk("cleared", 12'({statusByteOv, alertActive}), 12'h000);
         pulse(0);
         chk("trip", 12'({lowSideOn, statusByteOv, statusWordVout, statusVoutOv,
            alertActive}), 12'h01F);
         if (m[0] == 1'b0) begin
            pulse(2);
            chk("off time", 12'(lowSideOn), 12'h000);
            // Bounded wait for the next discharge pulse
            for (int k = 0; k < 8 && lowSideOn !== 1'b1; k++) #40;
            chk("pulse again", 12'(lowSideOn), 12'h001);
         end
         pulse(relEv[m]);
         chk("end state", 12'({latchedOff, outputHighZ, softStartRequest}),
            12'(expEnd[m]));
         if (m == 0) begin
            pulse(0);
            chk("latched retrip", 12'(lowSideOn), 12'h001);
            // Release again so the power cycle finds the latched state
            pulse(1);
            chk("latched again", 12'(latchedOff), 12'h001);
         end
         pulse(4);
      end
      $display("overvoltage test done");
      testDone();
   end
endmodule
